//--- core/isg_pkg.sv
// Constants for the interrupt source gating block
// What this block does
// - Internal requests go straight to the handler, seen within one cycle.
// - Outside stop mode, external requests pass a three-clock glitch filter.
// - Filter runs on undivided clock; latency is the same for every clockDivideField setting.
// - Outside stop mode, external pulses shorter than three undivided clocks are ignored.
// - All requests of one module merge into one module request.
// - Enabled external request under the module 0 mask gives switchback from power management once past the pin synchroniser and filter.
// - No request is served in an exception-window cycle; it is deferred.
// - Prefix value holds for exactly the next cycle, then clears.
// - Any prefix write opens an exception window on the following cycle.
// - Cleared module mask blocks module; set mask allows unless globally off.
// - Cleared local enable disables source; set enable fires on a set flag.
// - Hardware sets flags; they stay set until software clears them.
// - Fire needs global enable, mask, local enable, flag, and in-service clear.
// - In-service sets on vectoring, clears on return or pop instruction.
// - Fifteen CAN centers each have a flag and share one module request; rx and tx enables; CAN mask gates.
// - CAN error threshold requests only with error and global CAN enables.
// - Requests sampled on rising edge, serviced one cycle later.
// - Return instruction is never interrupted; two cycles between interrupts.
// - Global enable resets to zero.
package isg_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL   = 4'h0;
	localparam logic [3:0] ADDR_MASK      = 4'h1;
	localparam logic [3:0] ADDR_PREFIX    = 4'h2;
	localparam logic [3:0] ADDR_EXT_EN    = 4'h3;
	localparam logic [3:0] ADDR_EXT_FLAG  = 4'h4;
	localparam logic [3:0] ADDR_SRC_EN    = 4'h5;
	localparam logic [3:0] ADDR_SRC_FLAG  = 4'h6;
	localparam logic [3:0] ADDR_CAN_CTL   = 4'h7;
	localparam logic [3:0] ADDR_CAN_FLAG  = 4'h8;
	localparam logic [3:0] ADDR_CAN_RXEN  = 4'h9;
	localparam logic [3:0] ADDR_CAN_TXEN  = 4'hA;
	localparam logic [3:0] ADDR_PENDING   = 4'hB;
	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int CTL_GIE_BIT     = 0;
	localparam int CTL_INS_BIT     = 1;
	localparam int CANCTL_CAN_ERROR_IRQ_ENABLE_BIT = 0;
	localparam int CANCTL_GIE_BIT  = 1;
	localparam int NUM_MODULES     = 8;
	localparam int NUM_EXT         = 8;
	localparam int NUM_SRC         = 16;
	localparam int NUM_CENTERS     = 15;
	localparam int MOD_EXT         = 0;
	localparam int MOD_CAN         = 4;
	localparam int MOD_SYS         = 7;
	// Source slot groups in the generic source registers
	localparam logic [15:0] SRC_MOD0 = 16'h0003;
	localparam logic [15:0] SRC_MOD1 = 16'h000C;
	localparam logic [15:0] SRC_MOD2 = 16'h0030;
	localparam logic [15:0] SRC_MOD3 = 16'h00C0;
	localparam logic [15:0] SRC_MOD5 = 16'h1F00;
	localparam logic [15:0] SRC_MOD7 = 16'h8000;
	// ------------------------------------------------------------
	// Reset values and filter timing
	// ------------------------------------------------------------
	localparam logic [7:0]  CTL_RESET    = 8'h00;
	localparam logic [7:0]  MASK_RESET   = 8'h00;
	localparam logic [15:0] PREFIX_RESET = 16'h0000;
	localparam int          FILTER_LEN   = 3;
endpackage : isg_pkg

//--- core/isg_glitch_filter.sv
// Three-sample glitch filter on the undivided source clock
`timescale 1ns/1ps
module isg_glitch_filter (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstSync_n,
	// Control
	input  wire logic stopMode,
	// Pin and result
	input  wire logic pinIn,
	output logic      filtered
);
	logic [1:0]                    syncPin_q;
	logic [isg_pkg::FILTER_LEN-1:0] shift_q;

	// Two-stage pin synchroniser
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			syncPin_q <= 2'h0;
		else
			syncPin_q <= {syncPin_q[0], pinIn};
	end

	// Three consecutive highs to accept, bypass in stop mode
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			shift_q  <= '0;
			filtered <= 1'b0;
		end else begin
			shift_q <= {shift_q[isg_pkg::FILTER_LEN-2:0], syncPin_q[1]};
			if (stopMode)
				filtered <= syncPin_q[1];
			else
				filtered <= &shift_q;
		end
	end
endmodule // isg_glitch_filter

//--- core/isg_irq_gate.sv
// Interrupt request gating and exception window for the CPU sequencer
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module isg_irq_gate (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic [15:0]      regRdData,
	// External pins and clocking state
	input  wire logic [7:0]  extPin,
	input  wire logic        stopMode,
	input  wire logic        powerManageSelect,
	input  wire logic [1:0]  clockDivideField,
	// Internal flag set pulses
	input  wire logic [15:0] srcFlagSet,
	input  wire logic [14:0] centerFlagSet,
	input  wire logic        canErrThreshSet,
	// CPU sequencer
	input  wire logic        vectorAck,
	input  wire logic        returnFromIrqOp,
	input  wire logic        popIrqOp,
	output logic             irqRequest,
	output logic [7:0]       modulePending,
	output logic [15:0]      prefixValue,
	output logic             exceptionWindow,
	output logic             switchback
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rstSync_q;
	logic       rstSync_n;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			rstSync_q <= 2'h0;
		else
			rstSync_q <= {rstSync_q[0], 1'b1};
	end
	assign rstSync_n = rstSync_q[1];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic        globalIrqEnable_q;
	logic        inServiceBit_q;
	logic [7:0]  moduleMaskReg_q;
	logic [15:0] prefixHoldingReg_q;
	logic        prefixWritten_q;
	logic [7:0]  extEnable_q;
	logic [7:0]  extFlag_q;
	logic [15:0] srcEnable_q;
	logic [15:0] srcFlag_q;
	logic        canErrorIrqEnable_q;
	logic        canGlobalIrqEnable_q;
	logic        errorThresholdFlag_q;
	logic [14:0] centerRequestFlag_q;
	logic [14:0] centerRxIrqEnable_q;
	logic [14:0] centerTxIrqEnable_q;
	logic        irqRequest_q;
	logic        retiBlock_q;
	logic [7:0]  extFiltered;
	logic [7:0]  extFiltered_q;
	logic [7:0]  extRise;
	logic        wrCtl;
	logic        wrMask;
	logic        wrPfx;
	logic        wrExtEn;
	logic        wrExtFlag;
	logic        wrSrcEn;
	logic        wrSrcFlag;
	logic        wrCanCtl;
	logic        wrCanFlag;
	logic        wrRxEn;
	logic        wrTxEn;

	assign wrCtl     = regWrite && regAddr == isg_pkg::ADDR_CONTROL;
	assign wrMask    = regWrite && regAddr == isg_pkg::ADDR_MASK;
	assign wrPfx     = regWrite && regAddr == isg_pkg::ADDR_PREFIX;
	assign wrExtEn   = regWrite && regAddr == isg_pkg::ADDR_EXT_EN;
	assign wrExtFlag = regWrite && regAddr == isg_pkg::ADDR_EXT_FLAG;
	assign wrSrcEn   = regWrite && regAddr == isg_pkg::ADDR_SRC_EN;
	assign wrSrcFlag = regWrite && regAddr == isg_pkg::ADDR_SRC_FLAG;
	assign wrCanCtl  = regWrite && regAddr == isg_pkg::ADDR_CAN_CTL;
	assign wrCanFlag = regWrite && regAddr == isg_pkg::ADDR_CAN_FLAG;
	assign wrRxEn    = regWrite && regAddr == isg_pkg::ADDR_CAN_RXEN;
	assign wrTxEn    = regWrite && regAddr == isg_pkg::ADDR_CAN_TXEN;

	// ------------------------------------------------------------
	// External request filters
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < isg_pkg::NUM_EXT; gi++) begin : gExt
			isg_glitch_filter uFilt (
				.clk_sys   (clk_sys),
				.rstSync_n (rstSync_n),
				.stopMode  (stopMode),
				.pinIn     (extPin[gi]),
				.filtered  (extFiltered[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			extFiltered_q <= 8'h00;
		else
			extFiltered_q <= extFiltered;
	end
	assign extRise = extFiltered & ~extFiltered_q;

	// ------------------------------------------------------------
	// Control and mask
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			globalIrqEnable_q <= isg_pkg::CTL_RESET[0];
			moduleMaskReg_q   <= isg_pkg::MASK_RESET;
		end else begin
			if (wrCtl)
				globalIrqEnable_q <= regWrData[isg_pkg::CTL_GIE_BIT];
			if (wrMask)
				moduleMaskReg_q <= regWrData[7:0];
		end
	end

	// In-service: vectoring sets, return/pop clears, software may write
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			inServiceBit_q <= 1'b0;
		else if (vectorAck)
			inServiceBit_q <= 1'b1;
		else if (returnFromIrqOp || popIrqOp)
			inServiceBit_q <= 1'b0;
		else if (wrCtl)
			inServiceBit_q <= regWrData[isg_pkg::CTL_INS_BIT];
	end

	// ------------------------------------------------------------
	// Prefix register and exception window
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			prefixHoldingReg_q <= isg_pkg::PREFIX_RESET;
			prefixWritten_q    <= 1'b0;
		end else begin
			prefixHoldingReg_q <= wrPfx ? regWrData
				: isg_pkg::PREFIX_RESET;
			prefixWritten_q    <= wrPfx;
		end
	end
	assign prefixValue     = prefixHoldingReg_q;
	assign exceptionWindow = prefixWritten_q;

	// ------------------------------------------------------------
	// Flags: set wins over software clear (write one to clear)
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			extEnable_q <= 8'h00;
			extFlag_q   <= 8'h00;
		end else begin
			if (wrExtEn)
				extEnable_q <= regWrData[7:0];
			extFlag_q <= (extFlag_q & ~(wrExtFlag ? regWrData[7:0] : 8'h00))
				| extRise;
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			srcEnable_q <= 16'h0000;
			srcFlag_q   <= 16'h0000;
		end else begin
			if (wrSrcEn)
				srcEnable_q <= regWrData;
			srcFlag_q <= (srcFlag_q & ~(wrSrcFlag ? regWrData : 16'h0000))
				| srcFlagSet;
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			canErrorIrqEnable_q  <= 1'b0;
			canGlobalIrqEnable_q <= 1'b0;
			errorThresholdFlag_q <= 1'b0;
		end else begin
			if (wrCanCtl) begin
				canErrorIrqEnable_q  <= regWrData[isg_pkg::CANCTL_CAN_ERROR_IRQ_ENABLE_BIT];
				canGlobalIrqEnable_q <= regWrData[isg_pkg::CANCTL_GIE_BIT];
			end
			errorThresholdFlag_q <= canErrThreshSet
				|| (errorThresholdFlag_q && !(wrCanFlag && regWrData[15]));
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			centerRequestFlag_q <= 15'h0000;
			centerRxIrqEnable_q <= 15'h0000;
			centerTxIrqEnable_q <= 15'h0000;
		end else begin
			if (wrRxEn)
				centerRxIrqEnable_q <= regWrData[14:0];
			if (wrTxEn)
				centerTxIrqEnable_q <= regWrData[14:0];
			centerRequestFlag_q <= (centerRequestFlag_q
				& ~(wrCanFlag ? regWrData[14:0] : 15'h0000))
				| centerFlagSet;
		end
	end

	// ------------------------------------------------------------
	// Module request merge and gating
	// ------------------------------------------------------------
	logic [15:0] srcActive;
	logic [14:0] centerActive;
	logic [7:0]  modReq;
	logic        canErrReq;
	logic        fire;

	assign srcActive    = srcFlag_q & srcEnable_q;
	assign centerActive = centerRequestFlag_q
		& (centerRxIrqEnable_q | centerTxIrqEnable_q);
	assign canErrReq    = errorThresholdFlag_q && canErrorIrqEnable_q
		&& canGlobalIrqEnable_q;

	always_comb begin
		modReq = 8'h00;
		modReq[isg_pkg::MOD_EXT] = |(extFlag_q & extEnable_q)
			|| |(srcActive & isg_pkg::SRC_MOD0);
		modReq[1] = |(srcActive & isg_pkg::SRC_MOD1);
		modReq[2] = |(srcActive & isg_pkg::SRC_MOD2);
		modReq[3] = |(srcActive & isg_pkg::SRC_MOD3);
		modReq[isg_pkg::MOD_CAN] = |centerActive || canErrReq;
		modReq[5] = |(srcActive & isg_pkg::SRC_MOD5);
		modReq[isg_pkg::MOD_SYS] = |(srcActive & isg_pkg::SRC_MOD7);
	end

	assign modulePending = modReq;
	assign fire = globalIrqEnable_q && !inServiceBit_q
		&& |(modReq & moduleMaskReg_q);

	// Sample, then present one cycle later outside window and return
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			irqRequest_q <= 1'b0;
			retiBlock_q  <= 1'b0;
		end else begin
			irqRequest_q <= fire && !vectorAck;
			retiBlock_q  <= returnFromIrqOp;
		end
	end
	assign irqRequest = irqRequest_q && fire && !exceptionWindow
		&& !retiBlock_q && !returnFromIrqOp;

	// Switchback uses filtered, enabled external detection under the module mask on the fast clock
	assign switchback = powerManageSelect
		&& |(extFiltered & extEnable_q) && moduleMaskReg_q[isg_pkg::MOD_EXT];

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			regRdData <= 16'h0000;
		else if (regRead) begin
			unique case (regAddr)
				isg_pkg::ADDR_CONTROL:
					regRdData <= {14'h0000, inServiceBit_q, globalIrqEnable_q};
				isg_pkg::ADDR_MASK:     regRdData <= {8'h00, moduleMaskReg_q};
				isg_pkg::ADDR_PREFIX:   regRdData <= prefixHoldingReg_q;
				isg_pkg::ADDR_EXT_EN:   regRdData <= {8'h00, extEnable_q};
				isg_pkg::ADDR_EXT_FLAG: regRdData <= {8'h00, extFlag_q};
				isg_pkg::ADDR_SRC_EN:   regRdData <= srcEnable_q;
				isg_pkg::ADDR_SRC_FLAG: regRdData <= srcFlag_q;
				isg_pkg::ADDR_CAN_CTL:
					regRdData <= {14'h0000, canGlobalIrqEnable_q,
						canErrorIrqEnable_q};
				isg_pkg::ADDR_CAN_FLAG:
					regRdData <= {errorThresholdFlag_q, centerRequestFlag_q};
				isg_pkg::ADDR_CAN_RXEN: regRdData <= {1'b0, centerRxIrqEnable_q};
				isg_pkg::ADDR_CAN_TXEN: regRdData <= {1'b0, centerTxIrqEnable_q};
				isg_pkg::ADDR_PENDING:  regRdData <= {8'h00, modReq};
				default:                regRdData <= 16'h0000;
			endcase
		end
	end

	wire unusedDiv = ^clockDivideField;
endmodule // isg_irq_gate

//--- verif/isg_gate_monitor.sv
// Concurrent checks on the request gate ports
`timescale 1ns/1ps
module isg_gate_monitor (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// Register port
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        regWrite,
	// Sequencer and status
	input wire logic        powerManageSelect,
	input wire logic        vectorAck,
	input wire logic        returnFromIrqOp,
	input wire logic        irqRequest,
	input wire logic [7:0]  modulePending,
	input wire logic [15:0] prefixValue,
	input wire logic        exceptionWindow,
	input wire logic        switchback
);
	logic pfxWr;
	logic anyPend;
	assign pfxWr = regWrite && (regAddr == isg_pkg::ADDR_PREFIX);
	assign anyPend = |modulePending;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// ----
	// Prefix steps
	// ----
	sequence pfxLoad;
		pfxWr;
	endsequence
	sequence pfxHeld;
		exceptionWindow && (prefixValue == $past(regWrData));
	endsequence
	sequence pfxGone;
		(prefixValue == 16'h0000) && !exceptionWindow;
	endsequence
	prefix_hold_a: assert property (pfxLoad |=> pfxHeld)
		else $error("prefix value not held in next cycle");
	prefix_clear_a: assert property (pfxLoad ##1 !pfxWr |=> pfxGone)
		else $error("prefix value not cleared");
	window_cause_a: assert property (exceptionWindow |-> $past(pfxWr))
		else $error("window without prefix write");
	window_block_a: assert property (exceptionWindow |-> !irqRequest)
		else $error("request during window");
	return_from_irq_op_block_a: assert property (returnFromIrqOp |-> !irqRequest ##1 !irqRequest)
		else $error("request too close to return");
	vector_ins_a: assert property (vectorAck |=> !irqRequest)
		else $error("request while in service");
	request_cause_a: assert property (irqRequest |-> $past(anyPend))
		else $error("request without pending module");
	switch_cause_a: assert property (switchback |-> powerManageSelect)
		else $error("switchback outside power management");
endmodule // isg_gate_monitor

bind isg_irq_gate isg_gate_monitor i_isg_gate_monitor (.clk_sys, .reset_n,
	.regAddr, .regWrData, .regWrite, .powerManageSelect, .vectorAck,
	.returnFromIrqOp, .irqRequest, .modulePending, .prefixValue,
	.exceptionWindow, .switchback);

//--- verif/isg_cpu_model.sv
// Behavioural CPU sequencer that vectors on requests
`timescale 1ns/1ps
module isg_cpu_model (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       reset_n,
	// Bench control
	input wire logic       autoOn,
	input wire logic       usePop,
	input wire logic [3:0] svcLen,
	// Request side
	input wire logic       irqRequest,
	output logic           vectorAck,
	output logic           returnFromIrqOp,
	output logic           popIrqOp,
	output logic [7:0]     served
);
	logic       inSvc_q;
	logic [3:0] cnt_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			vectorAck       <= 1'b0;
			returnFromIrqOp <= 1'b0;
			popIrqOp        <= 1'b0;
			inSvc_q         <= 1'b0;
			cnt_q           <= 4'h0;
			served          <= 8'h00;
		end else begin
			vectorAck       <= 1'b0;
			returnFromIrqOp <= 1'b0;
			popIrqOp        <= 1'b0;
			if (inSvc_q) begin
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h0) begin
					inSvc_q         <= 1'b0;
					returnFromIrqOp <= !usePop;
					popIrqOp        <= usePop;
				end
			end else if (autoOn && irqRequest && !vectorAck) begin
				vectorAck <= 1'b1;
				inSvc_q   <= 1'b1;
				cnt_q     <= svcLen;
				served    <= served + 8'h01;
			end
		end
	end
endmodule // isg_cpu_model

//--- verif/interrupt_source_gating_tb.sv
// Self-checking bench for the request gate
`timescale 1ns/1ps
module interrupt_source_gating_tb;
	logic        clk_sys, reset_n, regWrite, regRead, stopMode;
	logic        powerManageSelect, canErrThreshSet, irqRequest;
	logic        exceptionWindow, switchback, vectorAck;
	logic        returnFromIrqOp, popIrqOp, autoOn, usePop;
	logic [3:0]  regAddr, svcLen;
	logic [15:0] regWrData, regRdData, srcFlagSet, prefixValue, v;
	logic [7:0]  extPin, modulePending, served, s0;
	logic [14:0] centerFlagSet;
	logic [1:0]  clockDivideField;
	logic [31:0] seed;
	int          fails, samplesChecked, cycles, k;
	isg_irq_gate i_isg_irq_gate (.clk_sys, .reset_n, .regAddr, .regWrData,
		.regWrite, .regRead, .regRdData, .extPin, .stopMode,
		.powerManageSelect, .clockDivideField, .srcFlagSet, .centerFlagSet,
		.canErrThreshSet, .vectorAck, .returnFromIrqOp, .popIrqOp,
		.irqRequest, .modulePending, .prefixValue, .exceptionWindow,
		.switchback);
	isg_cpu_model i_isg_cpu_model (.clk_sys, .reset_n, .autoOn, .usePop,
		.svcLen, .irqRequest, .vectorAck, .returnFromIrqOp, .popIrqOp,
		.served);
	// ----
	// Helpers
	// ----
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] merge(logic [15:0] f);
		return {|(f & isg_pkg::SRC_MOD7), 1'b0, |(f & isg_pkg::SRC_MOD5),
			1'b0, |(f & isg_pkg::SRC_MOD3), |(f & isg_pkg::SRC_MOD2),
			|(f & isg_pkg::SRC_MOD1), |(f & isg_pkg::SRC_MOD0)};
	endfunction
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic testDone();
		$display("checks %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk_sys);
		regWrite  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, logic [15:0] exp);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 check("read data", regRdData, exp);
	endtask
	task automatic pulse(logic [15:0] s, logic [14:0] c, logic t);
		@(posedge clk_sys);
		srcFlagSet      <= s;
		centerFlagSet   <= c;
		canErrThreshSet <= t;
		@(posedge clk_sys);
		srcFlagSet      <= 16'h0000;
		centerFlagSet   <= 15'h0000;
		canErrThreshSet <= 1'b0;
	endtask
	task automatic pin(int n);
		@(posedge clk_sys);
		extPin           <= 8'h01 << rnd() % 8;
		clockDivideField <= rnd() % 4;
		repeat (n) @(posedge clk_sys);
		extPin <= 8'h00;
	endtask
	// ----
	// Clock and timeout
	// ----
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			testDone();
		end
	end
	// ----
	// Main sequence
	// ----
	initial begin
		seed = 32'h0000D9C5;
		{regWrite, regRead, stopMode, powerManageSelect} = 4'h0;
		{canErrThreshSet, autoOn, usePop} = 3'h0;
		{regAddr, svcLen, clockDivideField} = 10'h000;
		{regWrData, srcFlagSet, centerFlagSet, extPin} = 55'h0;
		reset_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(isg_pkg::ADDR_CONTROL, 16'h0000);
		rd(isg_pkg::ADDR_MASK, 16'h0000);
		rd(4'hF, 16'h0000);
		wr(isg_pkg::ADDR_SRC_EN, 16'hFFFF);
		repeat (6) begin
			v = rnd();
			pulse(v, 15'h0000, 1'b0);
			tick(3);
			check("pending", {8'h00, modulePending}, {8'h00, merge(v)});
			wr(isg_pkg::ADDR_SRC_FLAG, 16'hFFFF);
			tick(1);
			check("cleared", {8'h00, modulePending}, 16'h0000);
		end
		for (int i = 0; i < 16; i++) begin
			wr(isg_pkg::ADDR_CONTROL, {14'h0, i[3], i[0]});
			wr(isg_pkg::ADDR_MASK, {15'h0, i[1]});
			wr(isg_pkg::ADDR_SRC_EN, {15'h0, i[2]});
			pulse(16'h0001, 15'h0000, 1'b0);
			tick(2);
			check("request", {15'h0, irqRequest}, {15'h0, i == 7});
			wr(isg_pkg::ADDR_SRC_FLAG, 16'h0001);
		end
		wr(isg_pkg::ADDR_CONTROL, 16'h0001);
		wr(isg_pkg::ADDR_MASK, 16'h00FF);
		wr(isg_pkg::ADDR_SRC_EN, 16'hFFFF);
		pulse(16'h0004, 15'h0000, 1'b0);
		#1 check("early", {15'h0, irqRequest}, 16'h0000);
		tick(1);
		check("sampled", {15'h0, irqRequest}, 16'h0001);
		v = rnd();
		wr(isg_pkg::ADDR_PREFIX, v);
		#1 check("window", {15'h0, exceptionWindow}, 16'h0001);
		check("prefix", prefixValue, v);
		check("deferred", {15'h0, irqRequest}, 16'h0000);
		tick(1);
		check("prefix gone", prefixValue, 16'h0000);
		check("resumed", {15'h0, irqRequest}, 16'h0001);
		svcLen <= 4'h4 + rnd() % 8;
		autoOn <= 1'b1;
		for (k = 0; k < 20 && vectorAck !== 1'b1; k++) tick(1);
		wr(isg_pkg::ADDR_SRC_FLAG, 16'h0004);
		tick(20);
		check("served", {8'h00, served}, 16'h0001);
		s0 = served;
		usePop <= 1'b1;
		svcLen <= 4'h0;
		pulse(16'h8000, 15'h0000, 1'b0);
		tick(30);
		check("repeat", {15'h0, served > s0 + 8'h01}, 16'h0001);
		autoOn <= 1'b0;
		wr(isg_pkg::ADDR_SRC_FLAG, 16'hFFFF);
		wr(isg_pkg::ADDR_CONTROL, 16'h0001);
		wr(isg_pkg::ADDR_MASK, 16'h0010);
		wr(isg_pkg::ADDR_CAN_RXEN, 16'h7FFF);
		for (int i = 0; i < 8; i++) begin
			wr(isg_pkg::ADDR_CAN_RXEN, {16{i[0]}} & 16'h7FFF);
			wr(isg_pkg::ADDR_CAN_TXEN, {16{i[1]}} & 16'h7FFF);
			wr(isg_pkg::ADDR_CAN_CTL, {14'h0, i[1], i[0]});
			pulse(16'h0000, i[2] ? 15'h0 : 15'h1 << rnd() % 15, i[2]);
			tick(2);
			v = {15'h0, i[2] ? i[0] & i[1] : i[0] | i[1]};
			check("can pending", {15'h0, modulePending[4]}, v);
			check("can request", {15'h0, irqRequest}, v);
			wr(isg_pkg::ADDR_CAN_FLAG, 16'hFFFF);
		end
		wr(isg_pkg::ADDR_EXT_EN, 16'h00FF);
		wr(isg_pkg::ADDR_MASK, 16'h0001);
		for (int n = 1; n < 6; n++) begin
			stopMode <= (n == 5);
			pin(n == 5 ? 1 : n);
			tick(12);
			check("ext", {15'h0, modulePending[0]}, {15'h0, n >= 3});
			wr(isg_pkg::ADDR_EXT_FLAG, 16'h00FF);
		end
		stopMode          <= 1'b0;
		powerManageSelect <= 1'b1;
		extPin            <= 8'h80;
		tick(10);
		check("switchback", {15'h0, switchback}, 16'h0001);
		@(posedge clk_sys);
		extPin            <= 8'h00;
		powerManageSelect <= 1'b0;
		tick(2);
		check("switch off", {15'h0, switchback}, 16'h0000);
		testDone();
	end
endmodule // interrupt_source_gating_tb
